// ==== irqc_regs.vh ====
// register offsets, field layouts, reset values and vectors for the interrupt controller
// assumes a 32-bit apb slave with one register per aligned word
`ifndef IRQC_REGS_VH
`define IRQC_REGS_VH

`define NUM_SRC 13
`define NUM_LVL_BITS 3

// byte offsets of the apb registers
`define OFF_IRQ_ENABLE 12'h000
`define OFF_EXT_IRQ_ENABLE 12'h004
`define OFF_PRIO_LOW 12'h008
`define OFF_PRIO_HIGH 12'h00C
`define OFF_EXT_PRIO_LOW 12'h010
`define OFF_EXT_PRIO_HIGH 12'h014
`define OFF_WDOG_CONTROL 12'h018
`define OFF_TIMER_CONTROL 12'h01C
`define OFF_EXT_IRQ_FLAG 12'h020
`define OFF_SER_TMR2_FLAG 12'h024
`define OFF_VECTOR_STATUS 12'h028
`define OFF_EVENT_STATUS 12'h02C
`define OFF_EVENT_MASK 12'h030

// field positions
`define BIT_GLOBAL_EN 7
`define BIT_PF_FLAG 4
`define BIT_PF_EN 5
`define BIT_WDOG_FLAG 3
`define BIT_IT0 0
`define BIT_EXT0_FLAG 1
`define BIT_IT1 2
`define BIT_EXT1_FLAG 3
`define BIT_TMR0_FLAG 5
`define BIT_TMR1_FLAG 7
`define BIT_WDOG_EN 4

// source indices in natural order
`define SRC_PF 0
`define SRC_EXT0 1
`define SRC_TMR0 2
`define SRC_EXT1 3
`define SRC_TMR1 4
`define SRC_SER0 5
`define SRC_TMR2 6
`define SRC_SER1 7
`define SRC_WDOG 12

// priority levels and vectors
`define LVL_PF 3'h4
`define LVL_IDLE 3'h7
`define VEC_PF 8'h33
`define VEC_BASE 8'h03
`define VEC_STEP 8'h08
`define VEC_SER1 8'h3B

`define RST_ZERO 8'h00
`endif

// ==== irq_arbiter.v ====
// combinational ranking of pending sources by level, then natural order
// assumes per-source pending and level inputs from the same clock domain
`timescale 1ns/1ps
`include "irqc_regs.vh"
module irq_arbiter #(
    parameter N = `NUM_SRC
) (
    input wire [N-1:0] pend,
    input wire [3*N-1:0] lvl,
    output reg found,
    output reg [3:0] win,
    output reg [2:0] win_lvl
);
    integer i;
    // scan from highest index downward; greater-or-equal lets the lower index take ties
    always @* begin
        found = 1'b0;
        win = 4'h0;
        win_lvl = 3'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pend[i] && (!found || lvl[3*i +: 3] >= win_lvl)) begin
                found = 1'b1;
                win = i[3:0];
                win_lvl = lvl[3*i +: 3];
            end
        end
    end
endmodule

// ==== irq_vector_rom.v ====
// registered vector address lookup per source index
// assumes the index is stable on the clock edge it is sampled
`timescale 1ns/1ps
`include "irqc_regs.vh"
module irq_vector_rom (
    input wire clk,
    input wire ce,
    input wire [3:0] idx,
    output reg [7:0] vec
);
    reg [7:0] vec_d;
    always @* begin
        if (idx == `SRC_PF) begin
            vec_d = `VEC_PF;
        end else if (idx == `SRC_SER1) begin
            vec_d = `VEC_SER1;
        end else if (idx < `SRC_SER1) begin
            vec_d = `VEC_BASE + ({4'h0, idx} - 8'h01) * `VEC_STEP;
        end else begin
            vec_d = `VEC_BASE + {4'h0, idx} * `VEC_STEP;
        end
    end
    always @(posedge clk) begin
        if (ce) begin
            vec <= vec_d;
        end
    end
endmodule

// ==== irq_controller.v ====
// five-level interrupt controller with apb register access and core vector handshake
// assumes pins are asynchronous, source events are same-clock one-cycle pulses
// Overview of operation
// - thirteen sources, each flag, enable, vector
// - maskable sources need own and global enable
// - global enable set permits enabled sources
// - global enable clear blocks maskable sources
// - power-fail gated by own enable only
// - five levels, level four for power-fail
// - enabled pending power-fail always wins
// - two priority bits, low and high registers
// - equal levels resolved by natural order
// - fixed natural order power-fail first, watchdog last
// - vectors 33h, 03h..63h, serial one 3Bh
// - flags set regardless of enable state
// - edge external 0/1 flags cleared on vectoring
// - level external flags follow the pin
// - timer0/1 flags cleared on vectoring
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "irqc_regs.vh"
module irq_controller #(
    parameter N = `NUM_SRC
) (
    // clock, reset, enable
    input wire REF_CLK,
    input wire RST,
    input wire CE,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // asynchronous pins, active low
    input wire EXT0_N,
    input wire EXT1_N,
    input wire [3:0] EXT25_N,
    // same-clock event pulses
    input wire POWERFAIL_EVT,
    input wire TMR0_OVF_EVT,
    input wire TMR1_OVF_EVT,
    input wire TMR2_OVF_EVT,
    input wire TMR2_EXT_EVT,
    input wire SER0_RX_EVT,
    input wire SER0_TX_EVT,
    input wire SER1_RX_EVT,
    input wire SER1_TX_EVT,
    input wire WDOG_EVT,
    // core handshake
    output reg VEC_REQ,
    output reg [7:0] VEC_ADDR,
    input wire VEC_ACK,
    input wire SVC_RETURN,
    // event interrupt
    output reg IRQ
);
    reg [7:0] irq_enable_q;
    reg [7:0] ext_irq_enable_q;
    reg [7:0] prio_low_q;
    reg [7:0] prio_high_q;
    reg [7:0] ext_prio_low_q;
    reg [7:0] ext_prio_high_q;
    reg powerfail_irq_enable_q;
    reg powerfail_flag_q;
    reg wdog_irq_flag_q;
    reg it0_q;
    reg it1_q;
    reg ext0_request_flag_q;
    reg ext1_request_flag_q;
    reg tmr0_overflow_flag_q;
    reg tmr1_overflow_flag_q;
    reg tmr2_overflow_flag_q;
    reg tmr2_external_flag_q;
    reg ser0_receive_flag_q;
    reg ser0_transmit_flag_q;
    reg ser1_receive_flag_q;
    reg ser1_transmit_flag_q;
    reg [3:0] ext25_flag_q;
    reg [5:0] pin_s1_q;
    reg [5:0] pin_s2_q;
    reg [5:0] pin_s3_q;
    reg [4:0] stack_q; // one bit per level in service
    reg [3:0] req_src_q;
    reg [2:0] req_lvl_q;
    reg [3:0] evt_status_q, evt_mask_q;
    wire [N-1:0] pend;
    wire [3*N-1:0] lvl;
    wire found;
    wire [3:0] win;
    wire [2:0] win_lvl;
    wire [7:0] vec;
    reg [2:0] cur_lvl;
    wire [N-1:0] flag_vec;
    wire [N-1:0] en_vec;
    wire [N-2:0] prio_lo, prio_hi;
    wire wr, rd;
    wire take;
    wire ack_evt;
    wire [5:0] pin_fall;
    wire [3:0] evt_now;
    integer k;

    assign wr = PSEL && PENABLE && PWRITE && !PREADY;
    assign rd = PSEL && PENABLE && !PWRITE && !PREADY;
    assign ack_evt = VEC_REQ && VEC_ACK;

    // level-triggered flags follow the synchronised pin, asserted when low
    assign flag_vec = {wdog_irq_flag_q, ext25_flag_q, ser1_receive_flag_q | ser1_transmit_flag_q,
                       tmr2_overflow_flag_q | tmr2_external_flag_q,
                       ser0_receive_flag_q | ser0_transmit_flag_q,
                       tmr1_overflow_flag_q, it1_q ? ext1_request_flag_q : !pin_s2_q[1],
                       tmr0_overflow_flag_q, it0_q ? ext0_request_flag_q : !pin_s2_q[0],
                       powerfail_flag_q};
    assign en_vec = {ext_irq_enable_q[4:0], irq_enable_q[6:0], powerfail_irq_enable_q};
    assign prio_lo = {ext_prio_low_q[4:0], prio_low_q[6:0]};
    assign prio_hi = {ext_prio_high_q[4:0], prio_high_q[6:0]};

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : src
            if (g == `SRC_PF) begin : pf
                assign pend[g] = flag_vec[g] && en_vec[g];
                assign lvl[3*g +: 3] = `LVL_PF;
            end else begin : mk
                // series and with the global enable
                assign pend[g] = flag_vec[g] && en_vec[g] && irq_enable_q[`BIT_GLOBAL_EN];
                assign lvl[3*g +: 3] = {1'b0, prio_hi[g-1], prio_lo[g-1]};
            end
        end
    endgenerate

    irq_arbiter #(.N(N)) u_arb (
        .pend(pend),
        .found(found),
        .lvl(lvl),
        .win(win),
        .win_lvl(win_lvl)
    );

    irq_vector_rom u_rom (
        .clk(REF_CLK),
        .ce(CE),
        .idx(win),
        .vec(vec)
    );

    // highest level currently in service; idle code means none
    always @* begin
        cur_lvl = `LVL_IDLE;
        for (k = 0; k < 5; k = k + 1) begin
            if (stack_q[k]) begin
                cur_lvl = k[2:0];
            end
        end
    end
    assign take = found && !VEC_REQ && (cur_lvl == `LVL_IDLE || win_lvl > cur_lvl);

    assign pin_fall = pin_s3_q & ~pin_s2_q;
    // vec from the rom lags one cycle, so the request rises two cycles after take, one after pending_q
    assign evt_now = {ack_evt && req_src_q == `SRC_PF, pin_fall[0] | pin_fall[1], ack_evt,
                      POWERFAIL_EVT};

    always @(posedge REF_CLK) begin
        if (RST) begin
            pin_s1_q <= 6'h3F;
            pin_s2_q <= 6'h3F;
            pin_s3_q <= 6'h3F;
        end else if (CE) begin
            pin_s1_q <= {~EXT25_N ^ 4'hF, EXT1_N, EXT0_N};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // core handshake: arbitrate, present vector, retire on ack
    reg pending_q;
    always @(posedge REF_CLK) begin
        if (RST) begin
            VEC_REQ <= 1'b0;
            VEC_ADDR <= `RST_ZERO;
            pending_q <= 1'b0;
            req_src_q <= 4'h0;
            req_lvl_q <= 3'h0;
            stack_q <= 5'h00;
        end else if (CE) begin
            if (SVC_RETURN && stack_q != 5'h00) begin
                stack_q[cur_lvl] <= 1'b0;
            end
            if (take && !pending_q) begin
                pending_q <= 1'b1;
                req_src_q <= win;
                req_lvl_q <= win_lvl;
            end else if (pending_q && !VEC_REQ) begin
                VEC_REQ <= 1'b1;
                VEC_ADDR <= vec;
            end else if (ack_evt) begin
                VEC_REQ <= 1'b0;
                pending_q <= 1'b0;
                stack_q[req_lvl_q] <= 1'b1;
            end
        end
    end

    // flags: hardware set wins over any clear in the same cycle
    always @(posedge REF_CLK) begin
        if (RST) begin
            irq_enable_q <= `RST_ZERO;
            ext_irq_enable_q <= `RST_ZERO;
            prio_low_q <= `RST_ZERO;
            prio_high_q <= `RST_ZERO;
            ext_prio_low_q <= `RST_ZERO;
            ext_prio_high_q <= `RST_ZERO;
            powerfail_irq_enable_q <= 1'b0;
            powerfail_flag_q <= 1'b0;
            wdog_irq_flag_q <= 1'b0;
            it0_q <= 1'b0;
            it1_q <= 1'b0;
            ext0_request_flag_q <= 1'b0;
            ext1_request_flag_q <= 1'b0;
            tmr0_overflow_flag_q <= 1'b0;
            tmr1_overflow_flag_q <= 1'b0;
            tmr2_overflow_flag_q <= 1'b0;
            tmr2_external_flag_q <= 1'b0;
            ser0_receive_flag_q <= 1'b0;
            ser0_transmit_flag_q <= 1'b0;
            ser1_receive_flag_q <= 1'b0;
            ser1_transmit_flag_q <= 1'b0;
            ext25_flag_q <= 4'h0;
            evt_status_q <= 4'h0;
            evt_mask_q <= 4'h0;
        end else if (CE) begin
            if (wr) begin
                case (PADDR)
                    `OFF_IRQ_ENABLE: irq_enable_q <= PWDATA[7:0];
                    `OFF_EXT_IRQ_ENABLE: ext_irq_enable_q <= PWDATA[7:0];
                    `OFF_PRIO_LOW: prio_low_q <= PWDATA[7:0];
                    `OFF_PRIO_HIGH: prio_high_q <= PWDATA[7:0];
                    `OFF_EXT_PRIO_LOW: ext_prio_low_q <= PWDATA[7:0];
                    `OFF_EXT_PRIO_HIGH: ext_prio_high_q <= PWDATA[7:0];
                    `OFF_WDOG_CONTROL: begin
                        powerfail_irq_enable_q <= PWDATA[`BIT_PF_EN];
                        if (!PWDATA[`BIT_PF_FLAG]) powerfail_flag_q <= 1'b0;
                        if (!PWDATA[`BIT_WDOG_FLAG]) wdog_irq_flag_q <= 1'b0;
                    end
                    `OFF_TIMER_CONTROL: begin
                        it0_q <= PWDATA[`BIT_IT0];
                        it1_q <= PWDATA[`BIT_IT1];
                        ext0_request_flag_q <= PWDATA[`BIT_EXT0_FLAG];
                        ext1_request_flag_q <= PWDATA[`BIT_EXT1_FLAG];
                        tmr0_overflow_flag_q <= PWDATA[`BIT_TMR0_FLAG];
                        tmr1_overflow_flag_q <= PWDATA[`BIT_TMR1_FLAG];
                    end
                    `OFF_EXT_IRQ_FLAG: ext25_flag_q <= ext25_flag_q & PWDATA[7:4];
                    `OFF_SER_TMR2_FLAG: begin
                        ser0_receive_flag_q <= ser0_receive_flag_q & PWDATA[0];
                        ser0_transmit_flag_q <= ser0_transmit_flag_q & PWDATA[1];
                        ser1_receive_flag_q <= ser1_receive_flag_q & PWDATA[2];
                        ser1_transmit_flag_q <= ser1_transmit_flag_q & PWDATA[3];
                        tmr2_external_flag_q <= tmr2_external_flag_q & PWDATA[6];
                        tmr2_overflow_flag_q <= tmr2_overflow_flag_q & PWDATA[7];
                    end
                    `OFF_EVENT_STATUS: evt_status_q <= evt_status_q & ~PWDATA[3:0];
                    `OFF_EVENT_MASK: evt_mask_q <= PWDATA[3:0];
                    default: ;
                endcase
            end
            // hardware clear on vectoring, for edge externals 0/1 and timer 0/1
            if (ack_evt && req_src_q == `SRC_EXT0 && it0_q) ext0_request_flag_q <= 1'b0;
            if (ack_evt && req_src_q == `SRC_EXT1 && it1_q) ext1_request_flag_q <= 1'b0;
            if (ack_evt && req_src_q == `SRC_TMR0) tmr0_overflow_flag_q <= 1'b0;
            if (ack_evt && req_src_q == `SRC_TMR1) tmr1_overflow_flag_q <= 1'b0;
            // sets regardless of enables, placed last so they win
            // no latch in level mode, so a later switch to edge mode starts clean
            if (pin_fall[0] && it0_q) ext0_request_flag_q <= 1'b1;
            if (pin_fall[1] && it1_q) ext1_request_flag_q <= 1'b1;
            ext25_flag_q <= (wr && PADDR == `OFF_EXT_IRQ_FLAG ? ext25_flag_q & PWDATA[7:4]
                             : ext25_flag_q) | pin_fall[5:2];
            if (POWERFAIL_EVT) powerfail_flag_q <= 1'b1;
            if (TMR0_OVF_EVT) tmr0_overflow_flag_q <= 1'b1;
            if (TMR1_OVF_EVT) tmr1_overflow_flag_q <= 1'b1;
            if (TMR2_OVF_EVT) tmr2_overflow_flag_q <= 1'b1;
            if (TMR2_EXT_EVT) tmr2_external_flag_q <= 1'b1;
            if (SER0_RX_EVT) ser0_receive_flag_q <= 1'b1;
            if (SER0_TX_EVT) ser0_transmit_flag_q <= 1'b1;
            if (SER1_RX_EVT) ser1_receive_flag_q <= 1'b1;
            if (SER1_TX_EVT) ser1_transmit_flag_q <= 1'b1;
            if (WDOG_EVT) wdog_irq_flag_q <= 1'b1;
            evt_status_q <= (wr && PADDR == `OFF_EVENT_STATUS ? evt_status_q & ~PWDATA[3:0]
                             : evt_status_q) | evt_now;
        end
    end

    always @(posedge REF_CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= |(evt_status_q & evt_mask_q);
        end
    end

    // apb: one wait state, pready pulses one cycle in the access phase
    always @(posedge REF_CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else if (CE) begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
            if (PSEL && PENABLE && !PREADY && PADDR > `OFF_EVENT_MASK) PSLVERR <= 1'b1;
            if (rd) begin
                case (PADDR)
                    `OFF_IRQ_ENABLE: PRDATA <= {24'h00_0000, irq_enable_q};
                    `OFF_EXT_IRQ_ENABLE: PRDATA <= {24'h00_0000, ext_irq_enable_q};
                    `OFF_PRIO_LOW: PRDATA <= {24'h00_0000, prio_low_q};
                    `OFF_PRIO_HIGH: PRDATA <= {24'h00_0000, prio_high_q};
                    `OFF_EXT_PRIO_LOW: PRDATA <= {24'h00_0000, ext_prio_low_q};
                    `OFF_EXT_PRIO_HIGH: PRDATA <= {24'h00_0000, ext_prio_high_q};
                    `OFF_WDOG_CONTROL: PRDATA <= {26'h000_0000, powerfail_irq_enable_q,
                                                 powerfail_flag_q, wdog_irq_flag_q, 3'h0};
                    `OFF_TIMER_CONTROL: PRDATA <= {24'h00_0000, tmr1_overflow_flag_q, 1'b0,
                                                  tmr0_overflow_flag_q, 1'b0, flag_vec[3],
                                                  it1_q, flag_vec[1], it0_q};
                    `OFF_EXT_IRQ_FLAG: PRDATA <= {24'h00_0000, ext25_flag_q, 4'h0};
                    `OFF_SER_TMR2_FLAG: PRDATA <= {24'h00_0000, tmr2_overflow_flag_q,
                                                  tmr2_external_flag_q, 2'h0,
                                                  ser1_transmit_flag_q, ser1_receive_flag_q,
                                                  ser0_transmit_flag_q, ser0_receive_flag_q};
                    `OFF_VECTOR_STATUS: PRDATA <= {16'h0000, 3'h0, stack_q, VEC_REQ,
                                                  cur_lvl, req_src_q};
                    `OFF_EVENT_STATUS: PRDATA <= {28'h000_0000, evt_status_q};
                    `OFF_EVENT_MASK: PRDATA <= {28'h000_0000, evt_mask_q};
                    default: PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ==== irq_controller_chk.sv ====
// concurrent checks on the apb and vector ports of irq_controller
// bound from the testbench top file, sees top-level ports only
`timescale 1ns/1ps
module irqc_chk #(
    parameter N = 13
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    // core handshake
    input wire VEC_REQ,
    input wire [7:0] VEC_ADDR,
    input wire VEC_ACK
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    sequence acc_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence pend_s;
        VEC_REQ && !VEC_ACK;
    endsequence
    apb_wait_a: assert property (acc_s |=> PREADY)
        else $error("ready missing after one wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held past one cycle");
    err_decode_a: assert property (PREADY |-> (PSLVERR == (PADDR > 12'h030)))
        else $error("slave error does not match address decode");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("slave error without ready");
    unmapped_zero_a: assert property (PREADY && !PWRITE && PSLVERR |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    // vector status is the one register wider than a byte
    upper_zero_a: assert property (PREADY && !PWRITE |-> PRDATA[31:13] == 19'h0_0000 &&
        (PRDATA[12:8] == 5'h00 || PADDR == 12'h028))
        else $error("upper read bits not zero");
    vec_hold_a: assert property (pend_s |=> VEC_REQ && $stable(VEC_ADDR))
        else $error("vector request dropped or changed before ack");
    vec_drop_a: assert property (VEC_REQ && VEC_ACK |=> !VEC_REQ)
        else $error("vector request held after ack");
    vec_table_a: assert property (VEC_REQ |-> VEC_ADDR[2:0] == 3'h3 && VEC_ADDR <= 8'h63)
        else $error("vector outside the table");
endmodule

// ==== core_seq_model.sv ====
// behavioural core sequencer: acks vector requests, returns after a hold
// assumes one clock shared with the controller, sync active-high reset
`timescale 1ns/1ps
module core_seq_model (
    // clock and reset
    input wire clk,
    input wire rst,
    // vector handshake
    input wire vec_req,
    input wire [7:0] vec_addr,
    output reg vec_ack = 1'b0,
    output reg svc_return = 1'b0,
    // pacing from the bench
    input wire [3:0] ack_wait,
    input wire [7:0] hold,
    // observation
    output reg [7:0] last_vec = 8'h00,
    output reg [7:0] vec_count = 8'h00,
    output reg [3:0] depth = 4'h0
);
    reg [3:0] wcnt = 4'h0;
    reg [7:0] left = 8'h00;
    // nested returns come out innermost first since each ack reloads the hold
    always @(posedge clk) begin
        vec_ack <= 1'b0;
        svc_return <= 1'b0;
        if (rst) begin
            wcnt <= 4'h0;
            depth <= 4'h0;
            vec_count <= 8'h00;
            left <= 8'h00;
        end else if (vec_req && !vec_ack) begin
            if (wcnt == ack_wait) begin
                vec_ack <= 1'b1;
                last_vec <= vec_addr;
                vec_count <= vec_count + 8'h01;
                depth <= depth + 4'h1;
                left <= hold;
                wcnt <= 4'h0;
            end else begin
                wcnt <= wcnt + 4'h1;
            end
        end else if (depth != 4'h0) begin
            if (left == 8'h00) begin
                svc_return <= 1'b1;
                depth <= depth - 4'h1;
                left <= hold;
            end else begin
                left <= left - 8'h01;
            end
        end
    end
endmodule

// ==== testbench.sv ====
// self-checking bench: apb register tasks, vector ordering through core model
// assumes irq_controller, irqc_chk and core_seq_model are compiled first
`timescale 1ns/1ps
module testbench;
    reg REF_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    reg [11:0] PADDR = 12'h000;
    reg [31:0] PWDATA = 32'h0000_0000;
    reg EXT0_N = 1, EXT1_N = 1;
    reg [3:0] EXT25_N = 4'hF;
    reg [9:0] evt = 10'h000;
    reg [3:0] ack_wait = 4'h0;
    reg [7:0] hold = 8'h28;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, VEC_REQ, VEC_ACK, SVC_RETURN, IRQ;
    wire [7:0] VEC_ADDR, last_vec, vec_count;
    wire [3:0] depth;
    reg [31:0] rdat;
    integer err_count = 0, check_count = 0, nvec = 0, i, n;
    irq_controller i_irq_controller (.REF_CLK(REF_CLK), .RST(RST), .CE(1'b1), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT0_N(EXT0_N), .EXT1_N(EXT1_N),
        .EXT25_N(EXT25_N), .POWERFAIL_EVT(evt[0]), .TMR0_OVF_EVT(evt[1]),
        .TMR1_OVF_EVT(evt[2]), .TMR2_OVF_EVT(evt[3]), .TMR2_EXT_EVT(evt[4]),
        .SER0_RX_EVT(evt[5]), .SER0_TX_EVT(evt[6]), .SER1_RX_EVT(evt[7]),
        .SER1_TX_EVT(evt[8]), .WDOG_EVT(evt[9]), .VEC_REQ(VEC_REQ), .VEC_ADDR(VEC_ADDR),
        .VEC_ACK(VEC_ACK), .SVC_RETURN(SVC_RETURN), .IRQ(IRQ));
    core_seq_model i_core_seq_model (.clk(REF_CLK), .rst(RST), .vec_req(VEC_REQ),
        .vec_addr(VEC_ADDR), .vec_ack(VEC_ACK), .svc_return(SVC_RETURN), .ack_wait(ack_wait),
        .hold(hold), .last_vec(last_vec), .vec_count(vec_count), .depth(depth));
    initial begin
        forever #4 REF_CLK = ~REF_CLK;
    end
    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one full apb transfer, released one edge before the next may start
    task apb(input w, input [11:0] a, input [7:0] d);
        begin
            PSEL <= 1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= {24'h00_0000, d};
            @(posedge REF_CLK);
            PENABLE <= 1;
            n = 0;
            @(posedge REF_CLK);
            while (PREADY !== 1'b1 && n < 40) begin
                @(posedge REF_CLK);
                n = n + 1;
            end
            rdat = PRDATA;
            check({PSLVERR, n < 40}, {a > 12'h030, 1'b1});
            PSEL <= 0;
            PENABLE <= 0;
            @(posedge REF_CLK);
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        apb(1, a, d);
    endtask
    task rd(input [11:0] a, input [7:0] exp);
        begin
            apb(0, a, 8'h00);
            check(rdat, {24'h00_0000, exp});
        end
    endtask
    task pulse(input [9:0] m);
        begin
            evt <= m;
            @(posedge REF_CLK);
            evt <= 10'h000;
            @(posedge REF_CLK);
        end
    endtask
    task wait_vec(input [7:0] exp);
        begin
            n = 0;
            while (vec_count == nvec[7:0] && n < 600) begin
                @(posedge REF_CLK);
                n = n + 1;
            end
            nvec = nvec + 1;
            check({n < 600, last_vec}, {1'b1, exp});
        end
    endtask
    task quiet;
        begin
            repeat (30) @(posedge REF_CLK);
            check(vec_count, nvec[7:0]);
        end
    endtask
    task idle;
        begin
            n = 0;
            while (depth != 4'h0 && n < 2000) begin
                @(posedge REF_CLK);
                n = n + 1;
            end
            check(depth, 4'h0);
            repeat (4) @(posedge REF_CLK);
        end
    endtask
    initial begin
        repeat (20000) @(posedge REF_CLK);
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge REF_CLK);
        RST <= 0;
        @(posedge REF_CLK);
        rd(12'h000, 8'h00);
        rd(12'h018, 8'h00);
        rd(12'h034, 8'h00);
        wr(12'h000, 8'h02);
        pulse(10'h002);
        quiet;
        rd(12'h01C, 8'h20);
        wr(12'h000, 8'h82);
        wait_vec(8'h0B);
        rd(12'h01C, 8'h00);
        wr(12'h000, 8'h80);
        pulse(10'h004);
        quiet;
        rd(12'h01C, 8'h80);
        wr(12'h000, 8'h88);
        wait_vec(8'h1B);
        wr(12'h000, 8'h00);
        wr(12'h018, 8'h20);
        pulse(10'h001);
        wait_vec(8'h33);
        rd(12'h018, 8'h30);
        wr(12'h018, 8'h00);
        rd(12'h02C, 8'h0B);
        wr(12'h030, 8'h01);
        check(IRQ, 1);
        wr(12'h02C, 8'h0F);
        rd(12'h02C, 8'h00);
        check(IRQ, 0);
        wr(12'h030, 8'h00);
        idle;
        // tmr1 at the top programmable level still loses to power-fail
        wr(12'h008, 8'h08);
        wr(12'h00C, 8'h08);
        wr(12'h000, 8'h88);
        wr(12'h018, 8'h20);
        pulse(10'h005);
        wait_vec(8'h33);
        wr(12'h018, 8'h00);
        wait_vec(8'h1B);
        idle;
        ack_wait <= 4'h3;
        wr(12'h008, 8'h02);
        wr(12'h000, 8'h8A);
        pulse(10'h006);
        wait_vec(8'h1B);
        wait_vec(8'h0B);
        idle;
        wr(12'h008, 8'h00);
        wr(12'h00C, 8'h0A);
        pulse(10'h006);
        wait_vec(8'h0B);
        wait_vec(8'h1B);
        idle;
        ack_wait <= 4'h0;
        hold <= 8'hC8;
        wr(12'h00C, 8'h00);
        wr(12'h008, 8'h10);
        wr(12'h000, 8'h9A);
        pulse(10'h002);
        wait_vec(8'h0B);
        pulse(10'h004);
        quiet;
        pulse(10'h020);
        wait_vec(8'h23);
        wr(12'h024, 8'h00);
        wait_vec(8'h1B);
        wr(12'h000, 8'h00);
        wr(12'h008, 8'h00);
        idle;
        hold <= 8'h28;
        wr(12'h01C, 8'h00);
        EXT0_N <= 0;
        repeat (6) @(posedge REF_CLK);
        rd(12'h01C, 8'h02);
        EXT0_N <= 1;
        repeat (6) @(posedge REF_CLK);
        rd(12'h01C, 8'h00);
        wr(12'h01C, 8'h05);
        // every maskable source, 1 to 12, alone in natural order, each with its own vector
        for (i = 1; i <= 12; i = i + 1) begin
            ack_wait <= i % 4;
            wr(12'h000, (i <= 7) ? (8'h80 | (8'h01 << (i - 1))) : 8'h80);
            wr(12'h004, (i <= 7) ? 8'h00 : (8'h01 << (i - 8)));
            case (i)
                1: EXT0_N <= 0;
                3: EXT1_N <= 0;
                2: pulse(10'h002);
                4: pulse(10'h004);
                5: pulse(10'h020);
                6: pulse(10'h010);
                7: pulse(10'h100);
                12: pulse(10'h200);
                default: EXT25_N <= ~(4'h1 << (i - 8));
            endcase
            wait_vec(8'h03 + 8'h08 * (i - (i < 7)));
            if (i <= 4) rd(12'h01C, 8'h05);
            EXT0_N <= 1;
            EXT1_N <= 1;
            EXT25_N <= 4'hF;
            wr(12'h020, 8'h00);
            wr(12'h024, 8'h00);
            wr(12'h018, 8'h00);
            wr(12'h000, 8'h00);
            wr(12'h004, 8'h00);
            idle;
        end
        tally_and_finish;
    end
endmodule
bind irq_controller irqc_chk #(.N(N)) u_chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .VEC_REQ(VEC_REQ), .VEC_ADDR(VEC_ADDR), .VEC_ACK(VEC_ACK));
